// [rtl/timer8_pkg.sv]
// constants, types and helpers shared by the 8-bit timer waveform block
// What this block does
// [RULE_01] mode code zero: counter only increments and wraps from 0xFF to 0x00
// [RULE_02] free-running: overflow flag set as counter becomes zero; counting never clears it
// [RULE_03] overflow flag clears itself when its interrupt is serviced
// [RULE_04] free-running: software may write the counter at any time
// [RULE_05] mode code 2: count up, clear when counter equals compare A
// [RULE_06] clear-on-match: compare A unbuffered; late low value waits for wrap
// [RULE_07] clear-on-match: compare A flag set each time counter reaches top
// [RULE_08] clear-on-match: action 1 inverts channel A output on each match
// [RULE_09] software sets pin direction to output before waveform reaches pin
// [RULE_10] toggle period is one plus compare A timer clocks
// [RULE_11] clear-on-match: overflow flag still set when counter passes max to zero
// [RULE_12] fast PWM counts zero to top then restarts; top 0xFF (3) or A (7)
// [RULE_13] fast PWM: overflow flag set each time counter reaches top
// [RULE_14] fast PWM: level at match, opposite at top to zero; 2 normal, 3 inverted
// [RULE_15] fast PWM with top 0xFF has a 256 timer clock period
// [RULE_16] fast PWM: compare zero gives spike, compare max gives constant level
// [RULE_17] fast PWM action 1 toggles on match; compare stays buffered
// [RULE_18] codes 1 and 5 count up to top and back down; top 0xFF or A
// [RULE_19] phase-correct: normal action clears on up match, sets on down match
// [RULE_20] phase-correct: counter holds top one timer clock, then counts down
// [RULE_21] phase-correct: overflow flag set each time counter reaches zero
// [RULE_22] counter equal to compare sets that channel flag next timer clock
// [RULE_23] PWM modes: compare writes buffered, loaded at top or bottom
// [RULE_24] software counter write beats any clear or count in that cycle
// [RULE_25] counter, flags and outputs change only when timer clock enable is high; counter writes, flag clears and forces act without it
package timer8_pkg;

   // apb register byte offsets
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] FORCE_OFS  = 12'h004;
   localparam logic [11:0] COUNT_OFS  = 12'h008;
   localparam logic [11:0] CMP_A_OFS  = 12'h00C;
   localparam logic [11:0] CMP_B_OFS  = 12'h010;
   localparam logic [11:0] FLAGS_OFS  = 12'h014;
   localparam logic [11:0] STATUS_OFS = 12'h018;

   // field positions
   localparam int MODE_LSB  = 0;
   localparam int ACT_A_LSB = 4;
   localparam int ACT_B_LSB = 6;
   localparam int OVF_BIT   = 0;
   localparam int CMP_A_BIT = 1;
   localparam int CMP_B_BIT = 2;
   localparam int UP_BIT    = 0;

   // reset values and fixed counts
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] CMP_RST   = 8'h00;
   localparam logic [7:0] MAX_VAL   = 8'hFF;
   localparam logic [7:0] BOTTOM    = 8'h00;
   localparam logic [7:0] CTRL_RST  = 8'h00;

   typedef enum logic [2:0] {
      MODE_NORMAL  = 3'h0,
      MODE_PC_MAX  = 3'h1,
      MODE_CLR     = 3'h2,
      MODE_FAST_MAX = 3'h3,
      MODE_RSV4    = 3'h4,
      MODE_PC_A    = 3'h5,
      MODE_RSV6    = 3'h6,
      MODE_FAST_A  = 3'h7
   } mode_e;

   typedef enum logic [1:0] {
      ACT_NONE   = 2'h0,
      ACT_TOGGLE = 2'h1,
      ACT_MATCH0 = 2'h2,
      ACT_MATCH1 = 2'h3
   } action_e;

   function automatic logic is_pwm(input mode_e m);
      return (m == MODE_PC_MAX) || (m == MODE_FAST_MAX) || (m == MODE_PC_A)
          || (m == MODE_FAST_A);
   endfunction

   function automatic logic is_pc(input mode_e m);
      return (m == MODE_PC_MAX) || (m == MODE_PC_A);
   endfunction

   function automatic logic is_fast(input mode_e m);
      return (m == MODE_FAST_MAX) || (m == MODE_FAST_A);
   endfunction

   function automatic logic top_is_a(input mode_e m);
      return (m == MODE_CLR) || (m == MODE_PC_A) || (m == MODE_FAST_A);
   endfunction

endpackage

// [rtl/count_if.sv]
// counter sequencing signals between the register side and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface count_if;
   logic               tick;
   timer8_pkg::mode_e  mode;
   logic [7:0]         top;
   logic               wr;
   logic [7:0]         wdata;
   logic [7:0]         count;
   logic               up;
   logic               at_top;
   logic               ovf_evt;

   modport ctl (output tick, mode, top, wr, wdata, input count, up, at_top, ovf_evt);
   modport seq (input tick, mode, top, wr, wdata, output count, up, at_top, ovf_evt);
endinterface
`default_nettype wire

// [rtl/count_sequencer.sv]
// counter and direction of the 8-bit timer for all waveform modes
`timescale 1ns/1ps
`default_nettype none
module count_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   count_if.seq     cif
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic       up_q;
   logic       up_d;
   logic       at_top;

   assign at_top      = (cnt_q == cif.top);
   assign cif.count   = cnt_q;
   assign cif.up      = up_q;
   assign cif.at_top  = at_top;

   // next count per mode
   always_comb begin
      up_d  = 1'b1;
      cnt_d = cnt_q + 8'h01;                                 // [RULE_01]
      if (timer8_pkg::is_pc(cif.mode)) begin
         up_d = at_top ? 1'b0 : ((cnt_q == timer8_pkg::BOTTOM) ? 1'b1 : up_q); // [RULE_20]
         if (at_top && cnt_q == timer8_pkg::BOTTOM) begin
            cnt_d = timer8_pkg::BOTTOM;                      // top of zero just sits
         end else if (!up_d) begin
            cnt_d = cnt_q - 8'h01;                           // [RULE_18]
         end
      end else if (cif.mode == timer8_pkg::MODE_CLR || timer8_pkg::is_fast(cif.mode)) begin
         // a top below the count is missed and met again after the wrap
         if (at_top) begin
            cnt_d = timer8_pkg::BOTTOM;                      // [RULE_05] [RULE_06] [RULE_12]
         end
      end
   end

   // overflow event, by mode
   always_comb begin
      cif.ovf_evt = 1'b0;
      if (cif.tick && !cif.wr) begin
         if (timer8_pkg::is_pc(cif.mode)) begin
            cif.ovf_evt = (cnt_q == timer8_pkg::BOTTOM);     // [RULE_21]
         end else if (timer8_pkg::is_fast(cif.mode)) begin
            cif.ovf_evt = at_top;                            // [RULE_13]
         end else begin
            cif.ovf_evt = (cnt_q == timer8_pkg::MAX_VAL);    // [RULE_02] [RULE_11]
         end
      end
   end

   // counter: software write wins over the timer step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= timer8_pkg::COUNT_RST;
      end else if (cif.wr) begin
         cnt_q <= cif.wdata;                                 // [RULE_24] [RULE_04]
      end else if (cif.tick) begin
         cnt_q <= cnt_d;                                     // [RULE_25]
      end
   end

   // direction only moves on a timer step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_q <= 1'b1;
      end else if (cif.tick && !cif.wr) begin
         up_q <= up_d;
      end
   end
endmodule
`default_nettype wire

// [rtl/timer8_waveform_modes.sv]
// 8-bit timer with two compare channels, waveform modes and an apb register file
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module timer8_waveform_modes (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        tick_en,
   input  wire logic        ovf_service_ack,
   input  wire logic [1:0]  cmp_service_ack,
   output logic             compare_a_output,
   output logic             compare_b_output
);

   // ------------------------------------------------------------------
   // local helpers
   // ------------------------------------------------------------------

   // word decode shared by the read mux and every write strobe
   function automatic logic reg_sel(input logic [11:0] a, input logic [11:0] ofs);
      return (a[11:2] == ofs[11:2]);
   endfunction

   // true when the address names any implemented register
   function automatic logic mapped(input logic [11:0] a);
      return reg_sel(a, timer8_pkg::CTRL_OFS)  || reg_sel(a, timer8_pkg::FORCE_OFS)
          || reg_sel(a, timer8_pkg::COUNT_OFS) || reg_sel(a, timer8_pkg::CMP_A_OFS)
          || reg_sel(a, timer8_pkg::CMP_B_OFS) || reg_sel(a, timer8_pkg::FLAGS_OFS)
          || reg_sel(a, timer8_pkg::STATUS_OFS);
   endfunction

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------

   count_if cif ();

   logic                  setup;
   logic                  access;
   logic                  wr_en;
   logic [31:0]           rd_mux;
   logic [31:0]           prdata_q;
   logic                  pready_q;
   logic                  pslverr_q;

   logic [7:0]            ctrl_q;
   timer8_pkg::mode_e     mode;
   timer8_pkg::action_e   action [2];
   logic                  pwm;

   logic                  wr_count;
   logic                  wr_force;
   logic                  wr_flags;
   logic [1:0]            wr_cmp;

   logic                  block_q;
   logic                  ovf_q;
   logic [7:0]            buf_q  [2];
   logic [7:0]            act_q  [2];
   logic                  out_q  [2];
   logic                  flag_q [2];
   logic [1:0]            match;
   logic [1:0]            force_hit;
   logic                  eff_up;

   // ------------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------------

   assign setup  = psel && !penable;
   assign access = psel && penable && pready_q;
   assign wr_en  = access && pwrite;

   // no wait state: the answer is prepared at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= setup;
      end
   end

   // unmapped words answer with an error, writes to them are dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= setup && !mapped(paddr);
      end
   end

   // read data is sampled one cycle before completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // read mux; unused bits read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (reg_sel(paddr, timer8_pkg::CTRL_OFS)) begin
         rd_mux[7:0] = ctrl_q;
      end else if (reg_sel(paddr, timer8_pkg::COUNT_OFS)) begin
         rd_mux[7:0] = cif.count;
      end else if (reg_sel(paddr, timer8_pkg::CMP_A_OFS)) begin
         rd_mux[7:0] = buf_q[0];
      end else if (reg_sel(paddr, timer8_pkg::CMP_B_OFS)) begin
         rd_mux[7:0] = buf_q[1];
      end else if (reg_sel(paddr, timer8_pkg::FLAGS_OFS)) begin
         rd_mux[timer8_pkg::OVF_BIT]   = ovf_q;
         rd_mux[timer8_pkg::CMP_A_BIT] = flag_q[0];
         rd_mux[timer8_pkg::CMP_B_BIT] = flag_q[1];
      end else if (reg_sel(paddr, timer8_pkg::STATUS_OFS)) begin
         rd_mux[timer8_pkg::UP_BIT] = cif.up;
         rd_mux[15:8]               = act_q[0];
         rd_mux[23:16]              = act_q[1];
      end
   end

   // write strobes, one cycle each, on the completing edge
   assign wr_count  = wr_en && reg_sel(paddr, timer8_pkg::COUNT_OFS);
   assign wr_force  = wr_en && reg_sel(paddr, timer8_pkg::FORCE_OFS);
   assign wr_flags  = wr_en && reg_sel(paddr, timer8_pkg::FLAGS_OFS);
   assign wr_cmp[0] = wr_en && reg_sel(paddr, timer8_pkg::CMP_A_OFS);
   assign wr_cmp[1] = wr_en && reg_sel(paddr, timer8_pkg::CMP_B_OFS);

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------

   // action bits act on the next match, they are never buffered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= timer8_pkg::CTRL_RST;
      end else if (wr_en && reg_sel(paddr, timer8_pkg::CTRL_OFS)) begin
         ctrl_q <= pwdata[7:0];
      end
   end

   assign mode      = timer8_pkg::mode_e'(ctrl_q[timer8_pkg::MODE_LSB +: 3]);
   assign action[0] = timer8_pkg::action_e'(ctrl_q[timer8_pkg::ACT_A_LSB +: 2]);
   assign action[1] = timer8_pkg::action_e'(ctrl_q[timer8_pkg::ACT_B_LSB +: 2]);
   assign pwm       = timer8_pkg::is_pwm(mode);

   // ------------------------------------------------------------------
   // counter sequencer
   // ------------------------------------------------------------------

   assign cif.tick  = tick_en;                               // [RULE_25]
   assign cif.mode  = mode;
   assign cif.wr    = wr_count;
   assign cif.wdata = pwdata[7:0];
   // top follows the active compare A, so in clear mode a late write is live at once
   assign cif.top   = timer8_pkg::top_is_a(mode) ? act_q[0] : timer8_pkg::MAX_VAL; // [RULE_12]

   count_sequencer u_seq (
      .pclk    (pclk),
      .presetn (presetn),
      .cif     (cif)
   );

   // a counter write masks the match of the next timer clock, even when stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_q <= 1'b0;
      end else if (wr_count) begin
         block_q <= 1'b1;
      end else if (tick_en) begin
         block_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // overflow flag
   // ------------------------------------------------------------------

   // set wins over service and software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_q <= 1'b0;
      end else if (cif.ovf_evt) begin
         ovf_q <= 1'b1;                                      // [RULE_02] [RULE_13] [RULE_21]
      end else if (ovf_service_ack || (wr_flags && pwdata[timer8_pkg::OVF_BIT])) begin
         ovf_q <= 1'b0;                                      // [RULE_03]
      end
   end

   // ------------------------------------------------------------------
   // compare channels
   // ------------------------------------------------------------------

   // phase-correct: a match at top counts as a down match, at bottom as an up match,
   // which keeps the extreme compare values constant and symmetric
   assign eff_up = (cif.count == cif.top) ? 1'b0 :
                   ((cif.count == timer8_pkg::BOTTOM) ? 1'b1 : cif.up);

   for (genvar n = 0; n < 2; n++) begin : g_ch

      assign match[n]     = tick_en && !block_q && !wr_count
                         && (cif.count == act_q[n]);
      // forcing only exists outside the pwm modes
      assign force_hit[n] = wr_force && pwdata[n] && !pwm;

      // software side of the compare value
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            buf_q[n] <= timer8_pkg::CMP_RST;
         end else if (wr_cmp[n]) begin
            buf_q[n] <= pwdata[7:0];
         end
      end

      // active compare value: direct outside pwm, loaded at top in pwm
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            act_q[n] <= timer8_pkg::CMP_RST;
         end else if (wr_cmp[n] && !pwm) begin
            act_q[n] <= pwdata[7:0];                         // [RULE_06]
         end else if (!pwm || (tick_en && !wr_count && cif.at_top)) begin
            act_q[n] <= buf_q[n];                            // [RULE_23] [RULE_17]
         end
      end

      // match flag, raised on the edge that ends the matching timer clock
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            flag_q[n] <= 1'b0;
         end else if (match[n]) begin
            flag_q[n] <= 1'b1;                               // [RULE_22] [RULE_07]
         end else if (cmp_service_ack[n] || (wr_flags && pwdata[timer8_pkg::CMP_A_BIT + n])) begin
            flag_q[n] <= 1'b0;
         end
      end

      // output state; keeps its value across mode changes
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            out_q[n] <= 1'b0;
         end else if (action[n] == timer8_pkg::ACT_NONE) begin
            out_q[n] <= out_q[n];
         end else if (timer8_pkg::is_fast(mode)) begin
            if (action[n] == timer8_pkg::ACT_TOGGLE) begin
               if (match[n]) begin
                  out_q[n] <= !out_q[n];                     // [RULE_17]
               end
            end else if (tick_en && !wr_count && cif.at_top) begin
               // the wrap wins so a compare at top gives a constant level
               out_q[n] <= (action[n] == timer8_pkg::ACT_MATCH0); // [RULE_14] [RULE_16]
            end else if (match[n]) begin
               out_q[n] <= (action[n] == timer8_pkg::ACT_MATCH1); // [RULE_14] [RULE_15]
            end
         end else if (timer8_pkg::is_pc(mode)) begin
            if (match[n] && action[n] != timer8_pkg::ACT_TOGGLE) begin
               // normal polarity clears going up and sets coming down
               out_q[n] <= (action[n] == timer8_pkg::ACT_MATCH0) ? !eff_up : eff_up; // [RULE_19]
            end
         end else if (match[n] || force_hit[n]) begin
            unique case (action[n])
               timer8_pkg::ACT_TOGGLE: out_q[n] <= !out_q[n]; // [RULE_08] [RULE_10]
               timer8_pkg::ACT_MATCH0: out_q[n] <= 1'b0;
               timer8_pkg::ACT_MATCH1: out_q[n] <= 1'b1;
               timer8_pkg::ACT_NONE:   out_q[n] <= out_q[n];
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // pin-side outputs
   // ------------------------------------------------------------------

   // the port logic outside still needs its direction set to show these
   assign compare_a_output = out_q[0];
   assign compare_b_output = out_q[1];

endmodule
`default_nettype wire

// [sim/pin_port_model.sv]
// port pin logic standing behind the compare outputs
`timescale 1ns/1ps
`default_nettype none
module pin_port_model (
   input  wire logic dir_out,
   input  wire logic level,
   output logic      pin
);
   // an input pin shows only its pull-up, never the internal waveform
   assign pin = dir_out ? level : 1'b1;
endmodule
`default_nettype wire

// [sim/timer8_waveform_modes_monitor.sv]
// port-level checker for the 8-bit timer waveform block
`timescale 1ns/1ps
`default_nettype none
module timer8_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        tick_en,
   input wire logic        ovf_service_ack,
   input wire logic [1:0]  cmp_service_ack,
   input wire logic        compare_a_output,
   input wire logic        compare_b_output
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // word index 6 is the last mapped register
   wire logic mapped = (paddr[11:2] <= 10'h006);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence done_s;
      psel && penable && pready;
   endsequence
   AST_READY_AFTER_SETUP: assert property (setup_s |=> done_s)
      else $error("no answer in first access cycle");
   AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   AST_UNMAPPED_ERR: assert property ((done_s and !mapped)
      |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   AST_MAPPED_OK: assert property ((done_s and mapped) |-> !pslverr)
      else $error("error on mapped access");
   AST_FORCE_READS_ZERO: assert property ((done_s and (!pwrite && paddr[11:2] == 10'h001))
      |-> prdata == 32'h0) else $error("force register read not zero");
   AST_UPPER_ZERO: assert property ((done_s and (!pwrite && paddr[11:2] != 10'h006))
      |-> prdata[31:8] == 24'h0) else $error("unused read bits set");
   AST_OUT_HOLD: assert property (
      !tick_en && !(psel && pwrite) |=> $stable(compare_a_output) && $stable(compare_b_output))
      else $error("output moved without a timer step");
endmodule
`default_nettype wire
bind timer8_waveform_modes timer8_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tick_en(tick_en), .ovf_service_ack(ovf_service_ack),
   .cmp_service_ack(cmp_service_ack), .compare_a_output(compare_a_output),
   .compare_b_output(compare_b_output));

// [sim/tb_top.sv]
// self-checking bench for the 8-bit timer waveform block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        tick_en;
   logic        ovf_ack;
   logic [1:0]  cmp_ack;
   logic        out_a;
   logic        out_b;
   logic        dir_out;
   logic        pin_a;
   logic [31:0] rdq;
   logic        err;
   int          n_fail = 0;
   int          checked = 0;
   int          cycles = 0;

   timer8_waveform_modes dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tick_en(tick_en), .ovf_service_ack(ovf_ack),
      .cmp_service_ack(cmp_ack), .compare_a_output(out_a), .compare_b_output(out_b));
   pin_port_model pin_u (.dir_out(dir_out), .level(out_a), .pin(pin_a));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // hang guard: the run needs about 1600 cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         stop_test();
      end
   end

   task automatic stop_test();
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer; tk raises the timer step during the access phase
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic tk);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      tick_en <= tk;
      // pready ends this wait; only the hang guard ends one that never sees it
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdq = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tick_en <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 1'b0);
      chk(nm, exp, rdq);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge pclk);
         tick_en <= 1'b1;
      end
      @(posedge pclk);
      tick_en <= 1'b0;
      // one idle edge so the last step's outputs have settled before a check
      @(posedge pclk);
   endtask

   task automatic ack(input logic [2:0] b);
      @(posedge pclk);
      ovf_ack <= b[0];
      cmp_ack <= b[2:1];
      @(posedge pclk);
      ovf_ack <= 1'b0;
      cmp_ack <= 2'h0;
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      tick_en = 1'b0;
      ovf_ack = 1'b0;
      cmp_ack = 2'h0;
      dir_out = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctrl", timer8_pkg::CTRL_OFS, 32'h0);
      rd("status", timer8_pkg::STATUS_OFS, 32'h1);
      // free-running wrap, flag and service
      wr(timer8_pkg::COUNT_OFS, 32'hFF);
      tick(1);
      rd("wrap", timer8_pkg::COUNT_OFS, 32'h0);
      tick(3);
      // both compares are still zero, so their flags rise at count zero too
      rd("ovf", timer8_pkg::FLAGS_OFS, 32'h7);
      ack(3'h7);
      rd("ovf ack", timer8_pkg::FLAGS_OFS, 32'h0);
      apb(1'b1, timer8_pkg::COUNT_OFS, 32'h40, 1'b1);
      rd("cnt wr", timer8_pkg::COUNT_OFS, 32'h40);
      // clear-on-match toggling with top 3
      wr(timer8_pkg::CMP_A_OFS, 32'h03);
      wr(timer8_pkg::COUNT_OFS, 32'h0);
      wr(timer8_pkg::CTRL_OFS, 32'h12);
      // output still low here, so a high pin can only be the pull-up
      chk("pin off", 32'h1, {31'h0, pin_a});
      tick(4);
      rd("ctc clr", timer8_pkg::COUNT_OFS, 32'h0);
      rd("ctc flag", timer8_pkg::FLAGS_OFS, 32'h2);
      dir_out <= 1'b1;
      tick(3);
      chk("toggle", 32'h1, {31'h0, pin_a});
      tick(1);
      chk("toggle2", 32'h0, {31'h0, out_a});
      ack(3'h6); // channel B matched at count zero as well
      // late top: counter runs through the wrap first
      wr(timer8_pkg::COUNT_OFS, 32'h0A);
      tick(246);
      rd("miss", timer8_pkg::COUNT_OFS, 32'h0);
      rd("ctc ovf", timer8_pkg::FLAGS_OFS, 32'h1);
      tick(4);
      rd("late hit", timer8_pkg::FLAGS_OFS, 32'h7);
      // fast pwm with top 0xFF, both polarities
      for (int a = 2; a <= 3; a++) begin
         wr(timer8_pkg::CTRL_OFS, 32'h03 | (a << 4) | (a << 6));
         wr(timer8_pkg::CMP_A_OFS, 32'h80);
         wr(timer8_pkg::COUNT_OFS, 32'hFF);
         wr(timer8_pkg::FLAGS_OFS, 32'h7);
         tick(1);
         rd("load", timer8_pkg::STATUS_OFS, 32'h8001);
         rd("fast ovf", timer8_pkg::FLAGS_OFS, 32'h1);
         chk("bottom", {31'h0, a == 2}, {31'h0, out_a});
         chk("spike", {31'h0, a == 2}, {31'h0, out_b});
         tick(128);
         chk("pre match", {31'h0, a == 2}, {31'h0, out_a});
         chk("spike end", {31'h0, a == 3}, {31'h0, out_b});
         tick(1);
         chk("match", {31'h0, a == 3}, {31'h0, out_a});
         tick(126);
         rd("top", timer8_pkg::COUNT_OFS, 32'hFF);
         tick(1);
         chk("period", {31'h0, a == 2}, {31'h0, out_a});
      end
      // fast pwm toggle: one flip per full count of 256 steps
      wr(timer8_pkg::CTRL_OFS, 32'h13);
      tick(129);
      chk("fast tgl", 32'h1, {31'h0, out_a});
      tick(256);
      chk("fast tgl2", 32'h0, {31'h0, out_a});
      // phase-correct with top 0xFF, output low before
      wr(timer8_pkg::CTRL_OFS, 32'h21);
      wr(timer8_pkg::CMP_A_OFS, 32'h10);
      wr(timer8_pkg::COUNT_OFS, 32'hFE);
      wr(timer8_pkg::FLAGS_OFS, 32'h7);
      tick(2);
      rd("top once", timer8_pkg::COUNT_OFS, 32'hFE);
      rd("down", timer8_pkg::STATUS_OFS, 32'h1000);
      tick(239);
      chk("down set", 32'h1, {31'h0, out_a});
      tick(15);
      rd("no ovf", timer8_pkg::FLAGS_OFS, 32'h2);
      tick(1);
      rd("pc ovf", timer8_pkg::FLAGS_OFS, 32'h7);
      tick(16);
      chk("up clr", 32'h0, {31'h0, out_a});
      // unmapped word is refused and reads zero
      apb(1'b0, 12'h01C, 32'h0, 1'b0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("bad rd", 32'h0, rdq);
      stop_test();
   end
endmodule
`default_nettype wire
